// [design/pis_pkg.sv]
// Package: register indices, field positions, masks and reset values for the peripheral IRQ block
package pis_pkg;
   localparam int            ADDR_W          = 3;
   localparam int            DATA_W          = 8;
   localparam logic [2:0]    ADDR_ENABLE_1   = 3'h0;
   localparam logic [2:0]    ADDR_ENABLE_2   = 3'h1;
   localparam logic [2:0]    ADDR_ENABLE_3   = 3'h2;
   localparam logic [2:0]    ADDR_REQUEST_1  = 3'h3;
   localparam logic [2:0]    ADDR_REQUEST_2  = 3'h4;
   localparam logic [2:0]    ADDR_REQUEST_3  = 3'h5;
   localparam logic [2:0]    ADDR_CONTROL    = 3'h6;
   localparam logic [2:0]    ADDR_STATUS     = 3'h7;
   // Bit positions, shared by each enable register and its request register
   localparam int            BIT_TIMER1_GATE = 7;
   localparam int            BIT_ADC_DONE    = 6;
   localparam int            BIT_TIMER2      = 1;
   localparam int            BIT_TIMER1_OVF  = 0;
   localparam int            BIT_COMPARATOR  = 5;
   localparam int            BIT_OSC_ACCUM   = 2;
   localparam int            BIT_CELL2       = 1;
   localparam int            BIT_CELL1       = 0;
   // Implemented-bit masks
   localparam logic [7:0]    MASK_1          = 8'hC3;
   localparam logic [7:0]    MASK_2          = 8'h24;
   localparam logic [7:0]    MASK_3          = 8'h03;
   localparam logic [7:0]    RESET_VALUE     = 8'h00;
   // Control register: global enable and peripheral gate
   localparam int            BIT_GLOBAL_EN   = 7;
   localparam int            BIT_PERIPH_GATE = 6;
   localparam logic [7:0]    MASK_CONTROL    = 8'hC0;
   // Status register: watchdog expiry (n) at 4, power-down (n) at 3, asleep at 0
   localparam int            BIT_WDT_EXP_N   = 4;
   localparam int            BIT_PWR_DOWN_N  = 3;
   localparam int            BIT_ASLEEP      = 0;
   localparam logic [7:0]    MASK_STATUS     = 8'h18;
   localparam logic [7:0]    RESET_STATUS    = 8'h18;
   localparam logic [15:0]   IRQ_VECTOR      = 16'h0004;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} pis_state_t;
endpackage

// [design/pis_flag_reg.sv]
// Leaf: one masked request register with hardware set priority over software write
`timescale 1ns/100ps
module pis_flag_reg #(
   parameter logic [7:0] MASK = 8'h00
) (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   input  wire logic [7:0] i_set,
   output logic      [7:0] o_value
);
   logic [7:0] flag_reg;
   logic [7:0] flag_next;

   // A set in the same cycle as a cleared write wins, so no event is lost
   assign flag_next = ((i_wr ? i_wdata : flag_reg) | i_set) & MASK;
   assign o_value   = flag_reg;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         flag_reg <= pis_pkg::RESET_VALUE;
      end else begin
         flag_reg <= flag_next;
      end
   end
endmodule

// [design/pis_periph_irq.sv]
// Top: peripheral interrupt enables, requests, request gating and sleep entry control
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module pis_periph_irq (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RESETN,
   input  wire logic [2:0]  I_ADDR,
   input  wire logic [7:0]  I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [7:0]  O_RDATA,
   input  wire logic        I_TIMER1_GATE_EVT,
   input  wire logic        I_ADC_DONE_EVT,
   input  wire logic        I_TIMER2_MATCH_EVT,
   input  wire logic        I_TIMER1_OVF_EVT,
   input  wire logic        I_COMPARATOR_EVT,
   input  wire logic        I_OSC_ACCUM_EVT,
   input  wire logic        I_CELL2_EVT,
   input  wire logic        I_CELL1_EVT,
   input  wire logic        I_SLEEP_EXEC,
   input  wire logic        I_IRQ_TAKEN,
   input  wire logic        I_WDT_SLEEP_EN,
   input  wire logic        I_TIMER1_ON_SLOW_CLK,
   input  wire logic        I_ADC_ON_RC_OSC,
   output logic             O_PERIPH_REQ,
   output logic             O_CPU_IRQ,
   output logic             O_FLUSH_PREFETCH,
   output logic             O_PUSH_PC,
   output logic      [15:0] O_VECTOR,
   output logic             O_CPU_CLK_EN,
   output logic             O_WDT_CLEAR,
   output logic             O_WDT_RUN,
   output logic             O_SLOW_OSC_EN,
   output logic             O_TIMER1_RUN,
   output logic             O_ADC_RUN,
   output logic             O_PIN_HOLD,
   output logic             O_WAKE
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register bus decode
   logic [7:0] en1_reg;
   logic [7:0] en2_reg;
   logic [7:0] en3_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] ctrl_next;
   logic [7:0] req1;
   logic [7:0] req2;
   logic [7:0] req3;
   logic [7:0] set1;
   logic [7:0] set2;
   logic [7:0] set3;
   logic [7:0] rdata_next;
   logic [7:0] rdata_reg;
   logic       wr_en1;
   logic       wr_en2;
   logic       wr_en3;
   logic       wr_req1;
   logic       wr_req2;
   logic       wr_req3;
   logic       wr_ctrl;
   logic       pending_any;
   logic       periph_req;
   logic       take_irq;
   logic       sleep_entry;
   logic       wake;
   pis_pkg::pis_state_t state_reg;
   pis_pkg::pis_state_t state_next;

   function automatic logic hit(input logic [2:0] addr, input logic [2:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   assign wr_en1  = I_WR && hit(I_ADDR, pis_pkg::ADDR_ENABLE_1);
   assign wr_en2  = I_WR && hit(I_ADDR, pis_pkg::ADDR_ENABLE_2);
   assign wr_en3  = I_WR && hit(I_ADDR, pis_pkg::ADDR_ENABLE_3);
   assign wr_req1 = I_WR && hit(I_ADDR, pis_pkg::ADDR_REQUEST_1);
   assign wr_req2 = I_WR && hit(I_ADDR, pis_pkg::ADDR_REQUEST_2);
   assign wr_req3 = I_WR && hit(I_ADDR, pis_pkg::ADDR_REQUEST_3);
   assign wr_ctrl = I_WR && hit(I_ADDR, pis_pkg::ADDR_CONTROL);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Event set vectors, placed at the documented bit positions
   always_comb begin
      set1 = pis_pkg::RESET_VALUE;
      set2 = pis_pkg::RESET_VALUE;
      set3 = pis_pkg::RESET_VALUE;
      set1[pis_pkg::BIT_TIMER1_GATE] = I_TIMER1_GATE_EVT;
      set1[pis_pkg::BIT_ADC_DONE]    = I_ADC_DONE_EVT;
      set1[pis_pkg::BIT_TIMER2]      = I_TIMER2_MATCH_EVT;
      set1[pis_pkg::BIT_TIMER1_OVF]  = I_TIMER1_OVF_EVT;
      set2[pis_pkg::BIT_COMPARATOR]  = I_COMPARATOR_EVT;
      set2[pis_pkg::BIT_OSC_ACCUM]   = I_OSC_ACCUM_EVT;
      set3[pis_pkg::BIT_CELL2]       = I_CELL2_EVT;
      set3[pis_pkg::BIT_CELL1]       = I_CELL1_EVT;
   end

   pis_flag_reg #(.MASK(pis_pkg::MASK_1)) u_req1 (
      .i_clock  (I_CLOCK),
      .i_resetn (I_RESETN),
      .i_wr     (wr_req1),
      .i_wdata  (I_WDATA),
      .i_set    (set1),
      .o_value  (req1)
   );

   pis_flag_reg #(.MASK(pis_pkg::MASK_2)) u_req2 (
      .i_clock  (I_CLOCK),
      .i_resetn (I_RESETN),
      .i_wr     (wr_req2),
      .i_wdata  (I_WDATA),
      .i_set    (set2),
      .o_value  (req2)
   );

   pis_flag_reg #(.MASK(pis_pkg::MASK_3)) u_req3 (
      .i_clock  (I_CLOCK),
      .i_resetn (I_RESETN),
      .i_wr     (wr_req3),
      .i_wdata  (I_WDATA),
      .i_set    (set3),
      .o_value  (req3)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Enable registers; only implemented bits are stored
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         en1_reg <= pis_pkg::RESET_VALUE;
         en2_reg <= pis_pkg::RESET_VALUE;
         en3_reg <= pis_pkg::RESET_VALUE;
      end else begin
         if (wr_en1) begin
            en1_reg <= I_WDATA & pis_pkg::MASK_1;
         end
         if (wr_en2) begin
            en2_reg <= I_WDATA & pis_pkg::MASK_2;
         end
         if (wr_en3) begin
            en3_reg <= I_WDATA & pis_pkg::MASK_3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Request gating and interrupt take
   // Flags are not cleared here; software must clear them before enabling a source
   assign pending_any  = |((req1 & en1_reg) | (req2 & en2_reg) | (req3 & en3_reg));
   assign periph_req   = pending_any && ctrl_reg[pis_pkg::BIT_PERIPH_GATE];
   assign take_irq     = periph_req && ctrl_reg[pis_pkg::BIT_GLOBAL_EN]
                         && (state_reg == pis_pkg::ST_RUN) && !I_IRQ_TAKEN;
   // Wake ignores the peripheral gate's partner, the global enable
   assign wake         = periph_req && (state_reg == pis_pkg::ST_SLEEP);
   // A sleep with an enabled request already pending and the peripheral gate set executes as a no-op
   assign sleep_entry  = I_SLEEP_EXEC && (state_reg == pis_pkg::ST_RUN) && !periph_req;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = I_WDATA & pis_pkg::MASK_CONTROL;
      end
      if (I_IRQ_TAKEN) begin
         ctrl_next[pis_pkg::BIT_GLOBAL_EN] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sleep state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pis_pkg::ST_RUN: begin
            if (sleep_entry) begin
               state_next = pis_pkg::ST_SLEEP;
            end
         end
         pis_pkg::ST_SLEEP: begin
            if (wake) begin
               state_next = pis_pkg::ST_WAKE;
            end
         end
         pis_pkg::ST_WAKE: begin
            state_next = pis_pkg::ST_RUN;
         end
         default: begin
            state_next = pis_pkg::ST_RUN;
         end
      endcase
   end

   always_comb begin
      status_next = status_reg;
      if (sleep_entry) begin
         status_next[pis_pkg::BIT_PWR_DOWN_N] = 1'b0;
         status_next[pis_pkg::BIT_WDT_EXP_N]  = 1'b1;
      end
   end

   // All resets stay asynchronous and act in every state, sleep included
   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_reg  <= pis_pkg::ST_RUN;
         ctrl_reg   <= pis_pkg::RESET_VALUE;
         status_reg <= pis_pkg::RESET_STATUS;
         rdata_reg  <= pis_pkg::RESET_VALUE;
      end else begin
         state_reg  <= state_next;
         ctrl_reg   <= ctrl_next;
         status_reg <= status_next;
         rdata_reg  <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read mux; unimplemented bits are already zero in storage
   always_comb begin
      rdata_next = pis_pkg::RESET_VALUE;
      if (I_RD) begin
         case (I_ADDR)
            pis_pkg::ADDR_ENABLE_1:  rdata_next = en1_reg;
            pis_pkg::ADDR_ENABLE_2:  rdata_next = en2_reg;
            pis_pkg::ADDR_ENABLE_3:  rdata_next = en3_reg;
            pis_pkg::ADDR_REQUEST_1: rdata_next = req1;
            pis_pkg::ADDR_REQUEST_2: rdata_next = req2;
            pis_pkg::ADDR_REQUEST_3: rdata_next = req3;
            pis_pkg::ADDR_CONTROL:   rdata_next = ctrl_reg;
            pis_pkg::ADDR_STATUS: begin
               rdata_next = status_reg & pis_pkg::MASK_STATUS;
               rdata_next[pis_pkg::BIT_ASLEEP] = (state_reg == pis_pkg::ST_SLEEP);
            end
            default:                 rdata_next = pis_pkg::RESET_VALUE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign O_RDATA          = rdata_reg;
   assign O_PERIPH_REQ     = periph_req;
   assign O_CPU_IRQ        = take_irq;
   assign O_FLUSH_PREFETCH = take_irq;
   assign O_PUSH_PC        = take_irq;
   assign O_VECTOR         = pis_pkg::IRQ_VECTOR;
   assign O_CPU_CLK_EN     = (state_reg != pis_pkg::ST_SLEEP);
   assign O_WDT_CLEAR      = sleep_entry;
   assign O_WDT_RUN        = (state_reg != pis_pkg::ST_SLEEP) || I_WDT_SLEEP_EN;
   assign O_SLOW_OSC_EN    = 1'b1;
   assign O_TIMER1_RUN     = (state_reg != pis_pkg::ST_SLEEP) || I_TIMER1_ON_SLOW_CLK;
   assign O_ADC_RUN        = (state_reg != pis_pkg::ST_SLEEP) || I_ADC_ON_RC_OSC;
   assign O_PIN_HOLD       = (state_reg == pis_pkg::ST_SLEEP);
   assign O_WAKE           = wake;
endmodule

// [testbench/pis_cpu_model.sv]
// Behavioural CPU core and peripheral event sources facing the peripheral IRQ block
`timescale 1ns/100ps
module pis_cpu_model #(
   parameter int ACK_DELAY = 2
) (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic [7:0] i_fire,
   input  wire logic       i_sleep_req,
   input  wire logic       i_auto_ack,
   input  wire logic       i_cpu_irq,
   output logic      [7:0] o_evt,
   output logic            o_sleep_exec,
   output logic            o_irq_taken
);
   int cnt_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Sources pulse only in the cycles the bench asks for, never stretched
   assign o_evt        = i_fire;
   assign o_sleep_exec = i_sleep_req;
   // Acknowledge is registered: a combinational answer would loop through the request
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_reg     <= 0;
         o_irq_taken <= 1'b0;
      end else begin
         o_irq_taken <= i_cpu_irq && i_auto_ack && (cnt_reg == ACK_DELAY - 1);
         cnt_reg     <= (i_cpu_irq && i_auto_ack && cnt_reg < ACK_DELAY - 1) ? cnt_reg + 1 : 0;
      end
   end
endmodule

// [testbench/pis_periph_irq_properties.sv]
// Concurrent checks on the ports of the peripheral IRQ block
`timescale 1ns/100ps
module pis_periph_irq_properties (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RESETN,
   input  wire logic        I_RD,
   input  wire logic        I_SLEEP_EXEC,
   input  wire logic        I_IRQ_TAKEN,
   input  wire logic        I_WDT_SLEEP_EN,
   input  wire logic        I_TIMER1_ON_SLOW_CLK,
   input  wire logic        I_ADC_ON_RC_OSC,
   input  wire logic [7:0]  O_RDATA,
   input  wire logic        O_PERIPH_REQ,
   input  wire logic        O_CPU_IRQ,
   input  wire logic        O_FLUSH_PREFETCH,
   input  wire logic        O_PUSH_PC,
   input  wire logic [15:0] O_VECTOR,
   input  wire logic        O_CPU_CLK_EN,
   input  wire logic        O_WDT_CLEAR,
   input  wire logic        O_WDT_RUN,
   input  wire logic        O_SLOW_OSC_EN,
   input  wire logic        O_TIMER1_RUN,
   input  wire logic        O_ADC_RUN,
   input  wire logic        O_PIN_HOLD,
   input  wire logic        O_WAKE
);
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RESETN);
   ////////////////////////////////////////////////////////////////////////////////
   AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data outside read slot");
   AST_IRQ_GATED: assert property (O_CPU_IRQ
      |-> O_PERIPH_REQ && O_CPU_CLK_EN && !I_IRQ_TAKEN)
      else $error("cpu request without gated peripheral request");
   AST_IRQ_ENTRY: assert property (O_FLUSH_PREFETCH == O_CPU_IRQ
      && O_PUSH_PC == O_CPU_IRQ && O_VECTOR == 16'h0004)
      else $error("interrupt entry signals disagree");
   AST_GLOBAL_CLEAR: assert property (I_IRQ_TAKEN |=> !O_CPU_IRQ)
      else $error("interrupt request survives acknowledge");
   AST_SLEEP_CAUSE: assert property (O_WDT_CLEAR
      |-> I_SLEEP_EXEC && !O_PERIPH_REQ && O_CPU_CLK_EN)
      else $error("sleep entry without sleep instruction");
   AST_SLEEP_ENTRY: assert property (O_WDT_CLEAR |=> !O_CPU_CLK_EN && O_PIN_HOLD)
      else $error("clock not stopped after sleep entry");
   AST_CLK_STOP: assert property ($fell(O_CPU_CLK_EN) |-> $past(O_WDT_CLEAR))
      else $error("clock stopped without watchdog clear");
   AST_RUN_CFG: assert property (
      O_WDT_RUN == (!O_PIN_HOLD || I_WDT_SLEEP_EN)
      && O_TIMER1_RUN == (!O_PIN_HOLD || I_TIMER1_ON_SLOW_CLK)
      && O_ADC_RUN == (!O_PIN_HOLD || I_ADC_ON_RC_OSC))
      else $error("run enables wrong for sleep state");
   AST_SLOW_OSC: assert property (O_SLOW_OSC_EN)
      else $error("slow oscillator stopped");
   AST_WAKE_CAUSE: assert property (O_WAKE == (O_PIN_HOLD && O_PERIPH_REQ))
      else $error("wake does not follow pending request");
   AST_WAKE_SEQ: assert property (O_WAKE |=> O_CPU_CLK_EN ##1 !O_PIN_HOLD)
      else $error("clock not restored after wake");
   AST_PIN_HOLD: assert property (O_PIN_HOLD == !O_CPU_CLK_EN)
      else $error("pin hold not tied to sleep");
   COV_SLEEP: cover property (O_WDT_CLEAR);
   COV_WAKE: cover property (O_WAKE);
   COV_TAKEN: cover property (O_PERIPH_REQ && I_IRQ_TAKEN);
   COV_SLEEP_WDT: cover property (O_PIN_HOLD && O_WDT_RUN);
endmodule
bind pis_periph_irq pis_periph_irq_properties i_pis_periph_irq_properties (
   .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_RD(I_RD), .I_SLEEP_EXEC(I_SLEEP_EXEC),
   .I_IRQ_TAKEN(I_IRQ_TAKEN), .I_WDT_SLEEP_EN(I_WDT_SLEEP_EN), .O_RDATA(O_RDATA),
   .I_TIMER1_ON_SLOW_CLK(I_TIMER1_ON_SLOW_CLK), .I_ADC_ON_RC_OSC(I_ADC_ON_RC_OSC),
   .O_PERIPH_REQ(O_PERIPH_REQ), .O_CPU_IRQ(O_CPU_IRQ), .O_FLUSH_PREFETCH(O_FLUSH_PREFETCH),
   .O_PUSH_PC(O_PUSH_PC), .O_VECTOR(O_VECTOR), .O_CPU_CLK_EN(O_CPU_CLK_EN),
   .O_WDT_CLEAR(O_WDT_CLEAR), .O_WDT_RUN(O_WDT_RUN), .O_SLOW_OSC_EN(O_SLOW_OSC_EN),
   .O_TIMER1_RUN(O_TIMER1_RUN), .O_ADC_RUN(O_ADC_RUN), .O_PIN_HOLD(O_PIN_HOLD), .O_WAKE(O_WAKE));

// [testbench/tb_top.sv]
// Self-checking bench for the peripheral IRQ block
`timescale 1ns/100ps
module tb_top;
   logic        clock, sleep_exec, taken, preq, irq, flush, push, clk_en, wdt_clr, wdt_run;
   logic        osc_en, t1_run, adc_run, hold, wake;
   logic        resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, sleep_req = 1'b0, auto_ack = 1'b0;
   logic        wdt_sl = 1'b0, t1_slow = 1'b1, adc_rc = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wdata = 8'h00, fire = 8'h00, rdata, evt;
   logic [7:0]  masks [3] = '{8'hC3, 8'h24, 8'h03};
   logic [15:0] vector;
   int          miscompares = 0, samples_checked = 0, n;
   ////////////////////////////////////////////////////////////////////////////////
   pis_cpu_model #(.ACK_DELAY(2)) i_pis_cpu_model (.i_clock(clock), .i_resetn(resetn),
      .i_fire(fire), .i_sleep_req(sleep_req), .i_auto_ack(auto_ack), .i_cpu_irq(irq),
      .o_evt(evt), .o_sleep_exec(sleep_exec), .o_irq_taken(taken));
   pis_periph_irq i_pis_periph_irq (.I_CLOCK(clock), .I_RESETN(resetn), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(bus_wr), .I_RD(bus_rd), .O_RDATA(rdata),
      .I_TIMER1_GATE_EVT(evt[7]), .I_ADC_DONE_EVT(evt[6]), .I_COMPARATOR_EVT(evt[5]),
      .I_OSC_ACCUM_EVT(evt[4]), .I_CELL2_EVT(evt[3]), .I_CELL1_EVT(evt[2]),
      .I_TIMER2_MATCH_EVT(evt[1]), .I_TIMER1_OVF_EVT(evt[0]), .I_SLEEP_EXEC(sleep_exec),
      .I_IRQ_TAKEN(taken), .I_WDT_SLEEP_EN(wdt_sl), .I_TIMER1_ON_SLOW_CLK(t1_slow),
      .I_ADC_ON_RC_OSC(adc_rc), .O_PERIPH_REQ(preq), .O_CPU_IRQ(irq), .O_FLUSH_PREFETCH(flush),
      .O_PUSH_PC(push), .O_VECTOR(vector), .O_CPU_CLK_EN(clk_en), .O_WDT_CLEAR(wdt_clr),
      .O_WDT_RUN(wdt_run), .O_SLOW_OSC_EN(osc_en), .O_TIMER1_RUN(t1_run),
      .O_ADC_RUN(adc_run), .O_PIN_HOLD(hold), .O_WAKE(wake));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   // The #1 lets the strobe edge land before anything is sampled
   task automatic reg_write(input logic [2:0] a, input logic [7:0] d, input logic [7:0] f);
      @(posedge clock);
      addr   <= a;
      wdata  <= d;
      bus_wr <= 1'b1;
      fire   <= f;
      @(posedge clock);
      bus_wr <= 1'b0;
      fire   <= 8'h00;
      #1;
   endtask
   task automatic reg_read(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      addr   <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1;
      chk_byte(what, exp, rdata);
   endtask
   task automatic sleep_pulse(input logic exp_clear);
      @(posedge clock);
      sleep_req <= 1'b1;
      #1;
      chk_bit("watchdog clear", exp_clear, wdt_clr);
      @(posedge clock);
      sleep_req <= 1'b0;
      #1;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) reg_read(i[2:0], (i == 7) ? 8'h18 : 8'h00, "reset");
      for (int i = 0; i < 6; i++) begin
         reg_write(i[2:0], 8'hFF, 8'h00);
         reg_read(i[2:0], masks[i % 3], "implemented bits");
         reg_write(i[2:0], 8'h00, 8'h00);
         reg_read(i[2:0], 8'h00, "cleared bits");
      end
      reg_write(3'h7, 8'h00, 8'h00);
      reg_read(3'h7, 8'h18, "status after write");
      $display("test registers done");
      reg_write(3'h7, 8'h00, 8'hFF);
      for (int i = 3; i < 6; i++) reg_read(i[2:0], masks[i % 3], "flags");
      reg_write(3'h6, 8'h40, 8'h00);
      chk_bit("request no enable", 1'b0, preq);
      reg_write(3'h0, 8'h02, 8'h00);
      chk_bit("gated request", 1'b1, preq);
      chk_bit("irq no global", 1'b0, irq);
      reg_write(3'h6, 8'h00, 8'h00);
      chk_bit("request no gate", 1'b0, preq);
      reg_write(3'h6, 8'h40, 8'h00);
      for (int i = 3; i < 6; i++) reg_write(i[2:0], 8'h00, 8'h00);
      chk_bit("cleared request", 1'b0, preq);
      reg_write(3'h3, 8'h00, 8'h02);
      reg_read(3'h3, 8'h02, "set beats clear");
      reg_write(3'h3, 8'h00, 8'h01);
      reg_read(3'h3, 8'h01, "clear and set");
      chk_bit("other source pending", 1'b0, preq);
      $display("test flags done");
      reg_write(3'h0, 8'h01, 8'h00);
      reg_write(3'h6, 8'h80, 8'h00);
      chk_bit("irq no gate", 1'b0, irq);
      reg_write(3'h6, 8'hC0, 8'h00);
      chk_bit("cpu irq", 1'b1, irq);
      chk_bit("flush", 1'b1, flush);
      chk_bit("push", 1'b1, push);
      chk_byte("vector", 8'h04, vector[7:0]);
      @(posedge clock);
      auto_ack <= 1'b1;
      for (n = 0; n < 20 && irq !== 1'b0; n++) @(posedge clock);
      if (n >= 20) begin
         miscompares++;
         complete_run;
      end
      auto_ack <= 1'b0;
      reg_read(3'h6, 8'h40, "global cleared");
      reg_write(3'h3, 8'h00, 8'h00);
      reg_write(3'h0, 8'h00, 8'h00);
      $display("test interrupt done");
      reg_write(3'h2, 8'h01, 8'h00);
      sleep_pulse(1'b1);
      chk_bit("cpu clock", 1'b0, clk_en);
      chk_bit("pin hold", 1'b1, hold);
      chk_bit("watchdog run", 1'b0, wdt_run);
      chk_bit("timer1 run", 1'b1, t1_run);
      chk_bit("adc run", 1'b0, adc_run);
      chk_bit("slow osc", 1'b1, osc_en);
      reg_read(3'h7, 8'h11, "status asleep");
      reg_write(3'h7, 8'h00, 8'h04);
      chk_bit("wake", 1'b1, wake);
      repeat (2) @(posedge clock);
      #1;
      chk_bit("clock back", 1'b1, clk_en);
      reg_read(3'h7, 8'h10, "status awake");
      sleep_pulse(1'b0);
      chk_bit("sleep refused", 1'b1, clk_en);
      reg_read(3'h7, 8'h10, "status after refusal");
      reg_write(3'h5, 8'h00, 8'h00);
      @(posedge clock);
      wdt_sl  <= 1'b1;
      t1_slow <= 1'b0;
      adc_rc  <= 1'b1;
      sleep_pulse(1'b1);
      chk_bit("watchdog run asleep", 1'b1, wdt_run);
      chk_bit("timer1 stopped", 1'b0, t1_run);
      chk_bit("adc run asleep", 1'b1, adc_run);
      $display("test sleep done");
      @(posedge clock);
      resetn <= 1'b0;
      #1;
      chk_bit("clock on reset in sleep", 1'b1, clk_en);
      chk_bit("pins released", 1'b0, hold);
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) reg_read(i[2:0], (i == 7) ? 8'h18 : 8'h00, "rerun");
      $display("test reset done");
      complete_run;
   end
endmodule
